//--- ccpad_map.vh
/*
 * Register indices, field positions, reset values and timing counts for
 * the codec control port and activity detector.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef CCPAD_MAP_VH
`define CCPAD_MAP_VH

// ----------------------------------------------------------------------
// Register indices (5-bit address space)
// ----------------------------------------------------------------------
`define CCPAD_ADDR_W          5
`define CCPAD_REG_EXTRA       5'h04
`define CCPAD_REG_POWER       5'h08
`define CCPAD_REG_FORMAT      5'h09
`define CCPAD_REG_OFF_LOW     5'h0b
`define CCPAD_REG_OFF_HIGH    5'h0c
`define CCPAD_REG_ON_COUNT    5'h0d
`define CCPAD_REG_REC_THR     5'h0e
`define CCPAD_REG_PLAY_THR    5'h0f
`define CCPAD_REG_STATUS      5'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define CCPAD_POWER_DIV_BIT   0
`define CCPAD_POWER_AUTO_BIT  4
`define CCPAD_FORMAT_SFS_BIT  0
`define CCPAD_EXTRA_GAIN_BIT  2
`define CCPAD_EXTRA_LOOP_BIT  0

// ----------------------------------------------------------------------
// Command codes in bits 7..5 of the first byte
// ----------------------------------------------------------------------
`define CCPAD_CMD_READ        3'h6
`define CCPAD_CMD_WRITE       3'h4

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define CCPAD_RESET_BYTE      8'h00
`define CCPAD_STARTUP_LOG2    21
`define CCPAD_FRAME_BITS      16

`endif

//--- ccpad_regfile.v
/*
 * Small 32 x 8 register memory of the control port, registered read data.
 * Assumes one write port and one read port on the master clock.
 */
`timescale 1ns/100ps
`include "ccpad_map.vh"

module ccpad_regfile #(
    parameter AW = `CCPAD_ADDR_W
) (
    input  wire          clk,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [7:0]    wdata,
    input  wire [AW-1:0] raddr,
    output reg  [7:0]    rdata_q
);

    reg [7:0] mem_q [0:(1<<AW)-1];

    // Write and registered read; the named registers are also kept in the main file
    always @(posedge clk)
    begin
        if (we)
        begin
            mem_q[waddr] <= wdata;
        end
        rdata_q <= mem_q[raddr];
    end

endmodule

//--- ccpad_top.v
/*
 * Codec control port slave and signal activity detectors.
 * Assumes port pins and audio sample strobes are synchronous to clk in
 * level, but the port clock is sampled here, so it must stay at or below
 * half of clk.
 */
`timescale 1ns/100ps
`include "ccpad_map.vh"

// Overview of operation
// - Startup latches divide, frame format and gain bits from port pin levels.
// - Register writes are accepted any time after startup, also during conversion.
// - Port is slave only; serial clock and select are never driven.
// - Data in changes on clock fall, sampled on clock rise.
// - Data out driven on clock fall, master samples on rise.
// - Each transaction is two bytes both ways, most significant bit first.
// - Read: first byte 110 plus address, then a second byte.
// - During a read the addressed register shifts out during byte two.
// - Write: first byte 100 plus address, second byte data stored.
// - Record flag is computed from converter output samples.
// - Playback flag is computed from audio serial input samples.
// - Shared 16-bit off-count, 8-bit on-count, separate thresholds.
// - Zero threshold, on-count or off-count forces the flag high.
// - Threshold compared with top eight bits of sample magnitude.
// - One comparison per sample period, once per frame sync.
// - Flag low: count samples above threshold; reaching on-count sets flag.
// - Flag high: count samples at or below threshold; reaching off-count clears flag.
// - In loopback the playback flag still follows serial input data.
// - Both flags read high after reset, as reset zeroes counts and thresholds.
// - Power bit 4 set powers playback down while its flag is low.
// - Startup ends after two to the twenty-first master clocks.
module ccpad_top #(
    parameter STARTUP_LOG2 = `CCPAD_STARTUP_LOG2
) (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        spi_sck,
    input  wire        spi_ss_n,
    input  wire        spi_mosi,
    output wire        spi_miso,
    output wire        spi_miso_oe_n,
    input  wire        frame_sync,
    input  wire [15:0] adc_sample,
    input  wire [15:0] audio_serial_in,
    output wire        reset_pin_n,
    output wire        master_clock_divider,
    output wire        short_frame_format,
    output wire        preamp_gain_x20,
    output wire        digital_loopback,
    output wire        playback_power_down,
    output wire        record_activity_flag,
    output wire        playback_activity_flag
);

    // ------------------------------------------------------------------
    // Startup counter
    // ------------------------------------------------------------------
    reg [STARTUP_LOG2:0] start_cnt_q;
    wire                 started = start_cnt_q[STARTUP_LOG2];

    // Counts master clocks after reset; the top bit marks the end
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            start_cnt_q <= {(STARTUP_LOG2+1){1'b0}};
        else if (!started)
            start_cnt_q <= start_cnt_q + 1'b1;
    end

    assign reset_pin_n = started;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    reg [2:0] sync1_q;
    reg [2:0] sync2_q;
    reg       sck_prev_q;

    // Two flops per pin and a third on the clock for edges; the first stage feeds no logic
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_q    <= 3'h3; // Idle levels: select and clock high
            sync2_q    <= 3'h3;
            sck_prev_q <= 1'b1;
        end
        else
        begin
            sync1_q    <= {spi_mosi, spi_sck, spi_ss_n};
            sync2_q    <= sync1_q;
            sck_prev_q <= sync2_q[1];
        end
    end

    wire ss_n_s  = sync2_q[0];
    wire sck_s   = sync2_q[1];
    wire mosi_s  = sync2_q[2];
    wire sck_ris = sck_s & ~sck_prev_q;
    wire sck_fal = ~sck_s & sck_prev_q;

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    reg  [7:0] power_q;
    reg  [7:0] format_q;
    reg  [7:0] extra_q;
    reg  [7:0] off_low_q;
    reg  [7:0] off_high_q;
    reg  [7:0] on_count_q;
    reg  [7:0] rec_thr_q;
    reg  [7:0] play_thr_q;
    reg        strap_done_q;
    reg        wr_en;
    reg  [4:0] wr_addr;
    reg  [7:0] wr_data;

    // Straps caught at end of startup, not under reset, from pin levels
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            power_q      <= `CCPAD_RESET_BYTE;
            format_q     <= `CCPAD_RESET_BYTE;
            extra_q      <= `CCPAD_RESET_BYTE;
            off_low_q    <= `CCPAD_RESET_BYTE;
            off_high_q   <= `CCPAD_RESET_BYTE;
            on_count_q   <= `CCPAD_RESET_BYTE;
            rec_thr_q    <= `CCPAD_RESET_BYTE;
            play_thr_q   <= `CCPAD_RESET_BYTE;
            strap_done_q <= 1'b0;
        end
        else if (started && !strap_done_q)
        begin
            strap_done_q <= 1'b1;
            power_q[`CCPAD_POWER_DIV_BIT]   <= ~ss_n_s;
            format_q[`CCPAD_FORMAT_SFS_BIT] <= ~sck_s;
            extra_q[`CCPAD_EXTRA_GAIN_BIT]  <= mosi_s;
        end
        else if (wr_en)
        begin
            // Writes land regardless of converter activity
            case (wr_addr)
                `CCPAD_REG_POWER:    power_q    <= wr_data;
                `CCPAD_REG_FORMAT:   format_q   <= wr_data;
                `CCPAD_REG_EXTRA:    extra_q    <= wr_data;
                `CCPAD_REG_OFF_LOW:  off_low_q  <= wr_data;
                `CCPAD_REG_OFF_HIGH: off_high_q <= wr_data;
                `CCPAD_REG_ON_COUNT: on_count_q <= wr_data;
                `CCPAD_REG_REC_THR:  rec_thr_q  <= wr_data;
                `CCPAD_REG_PLAY_THR: play_thr_q <= wr_data;
                default:             power_q    <= power_q;
            endcase
        end
    end

    assign master_clock_divider = power_q[`CCPAD_POWER_DIV_BIT];
    assign short_frame_format   = format_q[`CCPAD_FORMAT_SFS_BIT];
    assign preamp_gain_x20      = extra_q[`CCPAD_EXTRA_GAIN_BIT];
    assign digital_loopback     = extra_q[`CCPAD_EXTRA_LOOP_BIT];

    // ------------------------------------------------------------------
    // Serial port engine
    // ------------------------------------------------------------------
    localparam ST_IDLE = 3'b001;
    localparam ST_CMD  = 3'b010;
    localparam ST_DATA = 3'b100;

    reg  [2:0] state_q;
    reg  [3:0] bit_cnt_q;
    reg  [7:0] shift_in_q;
    reg  [7:0] cmd_q;
    reg  [7:0] shift_out_q;
    reg        miso_q;
    reg        load_q;
    wire [7:0] rd_data;
    wire [4:0] rd_addr = {shift_in_q[3:0], mosi_s};
    wire       is_read = (cmd_q[7:5] == `CCPAD_CMD_READ);
    wire       is_write = (cmd_q[7:5] == `CCPAD_CMD_WRITE);

    // Mirror memory supplies read data a cycle after the address settles
    ccpad_regfile #(
        .AW (`CCPAD_ADDR_W)
    ) u_regs (
        .clk     (clk),
        .we      (wr_en),
        .waddr   (wr_addr),
        .wdata   (wr_data),
        .raddr   (rd_addr),
        .rdata_q (rd_data)
    );

    // Status word overrides the memory so live flags can be read back
    wire [7:0] status_byte = {6'h00, playback_activity_flag, record_activity_flag};

    // Bits shift in on synchronised rising edges, out on falling edges
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q     <= ST_IDLE;
            bit_cnt_q   <= 4'h0;
            shift_in_q  <= 8'h00;
            cmd_q       <= 8'h00;
            shift_out_q <= 8'h00;
            miso_q      <= 1'b0;
            load_q      <= 1'b0;
            wr_en       <= 1'b0;
            wr_addr     <= 5'h00;
            wr_data     <= 8'h00;
        end
        else
        begin
            wr_en  <= 1'b0;
            load_q <= 1'b0;
            if (ss_n_s || !started)
            begin
                state_q   <= ST_IDLE;
                bit_cnt_q <= 4'h0;
                miso_q    <= 1'b0;
            end
            else
            begin
                // Named registers are read live, so reset values and straps read back
                if (load_q)
                begin
                    case (cmd_q[4:0])
                        `CCPAD_REG_POWER:    shift_out_q <= power_q;
                        `CCPAD_REG_FORMAT:   shift_out_q <= format_q;
                        `CCPAD_REG_EXTRA:    shift_out_q <= extra_q;
                        `CCPAD_REG_OFF_LOW:  shift_out_q <= off_low_q;
                        `CCPAD_REG_OFF_HIGH: shift_out_q <= off_high_q;
                        `CCPAD_REG_ON_COUNT: shift_out_q <= on_count_q;
                        `CCPAD_REG_REC_THR:  shift_out_q <= rec_thr_q;
                        `CCPAD_REG_PLAY_THR: shift_out_q <= play_thr_q;
                        `CCPAD_REG_STATUS:   shift_out_q <= status_byte;
                        default:             shift_out_q <= rd_data;
                    endcase
                end
                case (state_q)
                    ST_IDLE:
                    begin
                        state_q <= ST_CMD;
                    end
                    ST_CMD:
                    begin
                        if (sck_ris)
                        begin
                            shift_in_q <= {shift_in_q[6:0], mosi_s};
                            bit_cnt_q  <= bit_cnt_q + 4'h1;
                            if (bit_cnt_q == 4'h7)
                            begin
                                cmd_q   <= {shift_in_q[6:0], mosi_s};
                                load_q  <= 1'b1;
                                state_q <= ST_DATA;
                            end
                        end
                    end
                    ST_DATA:
                    begin
                        if (sck_fal && is_read)
                        begin
                            miso_q      <= shift_out_q[7];
                            shift_out_q <= {shift_out_q[6:0], 1'b0};
                        end
                        if (sck_ris)
                        begin
                            shift_in_q <= {shift_in_q[6:0], mosi_s};
                            bit_cnt_q  <= bit_cnt_q + 4'h1;
                            if (bit_cnt_q == 4'hf)
                            begin
                                state_q <= ST_IDLE;
                                // Only the write code stores
                                wr_en   <= is_write;
                                wr_addr <= cmd_q[4:0];
                                wr_data <= {shift_in_q[6:0], mosi_s};
                            end
                        end
                    end
                    default:
                    begin
                        state_q <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Slave only: data line driven during the second byte of a read, enable active low
    assign spi_miso      = miso_q;
    assign spi_miso_oe_n = ss_n_s | ~is_read | (state_q != ST_DATA);

    // ------------------------------------------------------------------
    // Activity detectors
    // ------------------------------------------------------------------
    // Upper eight bits of magnitude; saturates the most negative code
    function [7:0] mag_top;
        input [15:0] s;
        reg   [15:0] a;
        begin
            a = s[15] ? (~s + 16'h0001) : s;
            if (a[15])
                mag_top = 8'hff;
            else
                mag_top = a[14:7];
        end
    endfunction

    reg        fs_prev_q;
    reg        rec_flag_q;
    reg        play_flag_q;
    reg [15:0] rec_cnt_q;
    reg [15:0] play_cnt_q;

    wire        fs_rise   = frame_sync & ~fs_prev_q;
    wire [15:0] off_count = {off_high_q, off_low_q};
    wire        disabled  = (on_count_q == 8'h00) || (off_count == 16'h0000);
    wire        rec_above  = mag_top(adc_sample) > rec_thr_q;
    wire        play_above = mag_top(audio_serial_in) > play_thr_q;

    // Next count: increments while the run continues, else zero; returns 16 bits
    function [15:0] next_cnt;
        input        flag;
        input        above;
        input [15:0] cnt;
        begin
            if (flag ? ~above : above)
                next_cnt = cnt + 16'h0001;
            else
                next_cnt = 16'h0000;
        end
    endfunction

    // Hysteresis state per path, stepped once per frame
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fs_prev_q   <= 1'b0;
            rec_flag_q  <= 1'b0;
            play_flag_q <= 1'b0;
            rec_cnt_q   <= 16'h0000;
            play_cnt_q  <= 16'h0000;
        end
        else
        begin
            fs_prev_q <= frame_sync;
            if (fs_rise)
            begin
                rec_cnt_q  <= next_cnt(rec_flag_q, rec_above, rec_cnt_q);
                play_cnt_q <= next_cnt(play_flag_q, play_above, play_cnt_q);
                // Low: reach on-count to rise high: off-count to fall
                if (!rec_flag_q && next_cnt(1'b0, rec_above, rec_cnt_q) == {8'h00, on_count_q})
                begin
                    rec_flag_q <= 1'b1;
                    rec_cnt_q  <= 16'h0000;
                end
                else if (rec_flag_q && next_cnt(1'b1, rec_above, rec_cnt_q) == off_count)
                begin
                    rec_flag_q <= 1'b0;
                    rec_cnt_q  <= 16'h0000;
                end
                if (!play_flag_q && next_cnt(1'b0, play_above, play_cnt_q) == {8'h00, on_count_q})
                begin
                    play_flag_q <= 1'b1;
                    play_cnt_q  <= 16'h0000;
                end
                else if (play_flag_q && next_cnt(1'b1, play_above, play_cnt_q) == off_count)
                begin
                    play_flag_q <= 1'b0;
                    play_cnt_q  <= 16'h0000;
                end
            end
        end
    end

    // Zero parameter disables detection by forcing the flag high
    assign record_activity_flag   = rec_flag_q | disabled | (rec_thr_q == 8'h00);
    assign playback_activity_flag = play_flag_q | disabled | (play_thr_q == 8'h00);

    // Automatic playback power down follows the playback flag
    assign playback_power_down = power_q[`CCPAD_POWER_AUTO_BIT]
                                 & ~playback_activity_flag;

endmodule

//--- ccpad_assertions.sv
/* Checker on the control port and activity detector pins.
   Assumes binding to ccpad_top, startup parameter handed on. */
`timescale 1ns/100ps
module ccpad_assertions #(
    parameter STARTUP_LOG2 = 21
) (
    input wire        clk,
    input wire        reset_n,
    input wire        spi_sck,
    input wire        spi_ss_n,
    input wire        spi_mosi,
    input wire        spi_miso,
    input wire        spi_miso_oe_n,
    input wire        frame_sync,
    input wire [15:0] adc_sample,
    input wire [15:0] audio_serial_in,
    input wire        reset_pin_n,
    input wire        master_clock_divider,
    input wire        short_frame_format,
    input wire        preamp_gain_x20,
    input wire        digital_loopback,
    input wire        playback_power_down,
    input wire        record_activity_flag,
    input wire        playback_activity_flag
);
// ---------------------------------------------------------------
// Clocks since reset release
// ---------------------------------------------------------------
localparam int START = 1 << STARTUP_LOG2;
int unsigned up_q;
// Saturates so a long run never wraps
always @(posedge clk or negedge reset_n)
begin
    if (!reset_n)
        up_q <= 0;
    else if (up_q < START + 4)
        up_q <= up_q + 1;
end
default clocking cb @(posedge clk); endclocking
default disable iff (!reset_n);
// ---------------------------------------------------------------
// Properties
// ---------------------------------------------------------------
AST_STARTUP_LOW: assert property (up_q < START - 1 |-> !reset_pin_n)
    else $error("reset pin released early");
AST_STARTUP_RISE: assert property ($rose(reset_pin_n)
    |-> up_q inside {[START-1:START+2]})
    else $error("reset pin rose at wrong count");
AST_CONFIG_CAUSE: assert property ($changed({master_clock_divider,
    short_frame_format, preamp_gain_x20, digital_loopback})
    |-> !$past(spi_ss_n, 2) || !$past(reset_pin_n, 4))
    else $error("config bit moved without write or startup");
AST_REC_FRAME: assert property ($changed(record_activity_flag)
    |-> $past(frame_sync, 1) || $past(frame_sync, 2) || $past(frame_sync, 3)
    || !$past(spi_ss_n, 2))
    else $error("record flag moved without a sample");
AST_PLAY_FRAME: assert property ($changed(playback_activity_flag)
    |-> $past(frame_sync, 1) || $past(frame_sync, 2) || $past(frame_sync, 3)
    || !$past(spi_ss_n, 2))
    else $error("playback flag moved without a sample");
AST_POWER_DOWN: assert property (playback_activity_flag |-> !playback_power_down)
    else $error("playback powered down while active");
AST_POWER_CAUSE: assert property ($rose(playback_power_down)
    |-> $fell(playback_activity_flag) || !$past(spi_ss_n, 2))
    else $error("playback power down without flag fall or write");
AST_OE_IDLE: assert property (spi_ss_n [*4] |-> spi_miso_oe_n)
    else $error("data out enabled while deselected");
AST_MISO_FALL: assert property ($changed(spi_miso) && !spi_miso_oe_n && !spi_ss_n
    |-> $past(spi_sck, 5) && !$past(spi_sck, 1))
    else $error("data out moved away from clock fall");
AST_MISO_IDLE: assert property (spi_ss_n [*6] |-> !spi_miso)
    else $error("data out not idle low");
endmodule

bind ccpad_top ccpad_assertions #(.STARTUP_LOG2(STARTUP_LOG2)) u_chk (.clk, .reset_n,
    .spi_sck, .spi_ss_n, .spi_mosi, .spi_miso, .spi_miso_oe_n, .frame_sync, .adc_sample,
    .audio_serial_in, .reset_pin_n, .master_clock_divider, .short_frame_format,
    .preamp_gain_x20, .digital_loopback, .playback_power_down, .record_activity_flag,
    .playback_activity_flag);

//--- ccpad_spi_master.sv
/* Port master model for the serial control port.
   Assumes clk is the device master clock; clock idles high. */
`timescale 1ns/100ps
module ccpad_spi_master (
    input  wire  clk,
    input  wire  spi_miso,
    output logic spi_sck,
    output logic spi_ss_n,
    output logic spi_mosi
);
initial
begin
    spi_sck = 1'b1;
    spi_ss_n = 1'b1;
    spi_mosi = 1'b0;
end
// Pin levels held through startup
task pins(input logic s, input logic k, input logic d);
    begin
        spi_ss_n <= s;
        spi_sck <= k;
        spi_mosi <= d;
    end
endtask
// ---------------------------------------------------------------
// One transfer of n bits, ten clocks per bit, short n aborts
// ---------------------------------------------------------------
task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    int i;
    begin
        rx = '0;
        @(posedge clk);
        spi_ss_n <= 1'b0;
        repeat (16) @(posedge clk); // Select-to-clock recovery, above 125 ns
        for (i = 0; i < n; i++)
        begin
            spi_sck <= 1'b0;
            spi_mosi <= tx[15-i];
            repeat (5) @(posedge clk);
            spi_sck <= 1'b1;
            rx = {rx[14:0], spi_miso};
            repeat (5) @(posedge clk);
        end
        spi_ss_n <= 1'b1;
        spi_mosi <= ~spi_mosi; // Released line, no stale level
        repeat (5) @(posedge clk);
    end
endtask
endmodule

//--- ccpad_top_tb.sv
/* Self-checking bench for control port and activity detectors.
   Assumes a shortened startup count set by parameter. */
`timescale 1ns/100ps
`include "ccpad_map.vh"
module ccpad_top_tb;
typedef struct packed { logic [4:0] a; logic [7:0] d; } ccpad_row_t;
logic clk, reset_n, frame_sync, spi_sck, spi_ss_n, spi_mosi, spi_miso, spi_miso_oe_n;
logic [15:0] adc_sample, audio_serial_in, rx;
logic reset_pin_n, master_clock_divider, short_frame_format, preamp_gain_x20;
logic digital_loopback, playback_power_down, record_activity_flag, playback_activity_flag;
int num_errors, n_tests, i;
// Writes, then read back; last row is a plain memory place
ccpad_row_t rows [9] = '{'{`CCPAD_REG_OFF_LOW, 8'h02}, '{`CCPAD_REG_OFF_HIGH, 8'h00},
    '{`CCPAD_REG_ON_COUNT, 8'h03}, '{`CCPAD_REG_REC_THR, 8'h04}, '{`CCPAD_REG_PLAY_THR, 8'h04},
    '{`CCPAD_REG_EXTRA, 8'h01}, '{`CCPAD_REG_POWER, 8'h10}, '{`CCPAD_REG_FORMAT, 8'h00},
    '{5'h1f, 8'ha5}};
ccpad_top #(.STARTUP_LOG2(4)) dut (.clk, .reset_n, .spi_sck, .spi_ss_n, .spi_mosi,
    .spi_miso, .spi_miso_oe_n, .frame_sync, .adc_sample, .audio_serial_in, .reset_pin_n,
    .master_clock_divider, .short_frame_format, .preamp_gain_x20, .digital_loopback,
    .playback_power_down, .record_activity_flag, .playback_activity_flag);
ccpad_spi_master master (.clk, .spi_miso, .spi_sck, .spi_ss_n, .spi_mosi);
initial
begin
    clk = 1'b0;
    forever #4 clk = ~clk;
end
// ---------------------------------------------------------------
// Shared tasks
// ---------------------------------------------------------------
task results;
    begin
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    end
endtask
task chk(input [7:0] seen, input [7:0] exp);
    begin
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    end
endtask
task wr(input [4:0] a, input [7:0] d);
    master.xfer({`CCPAD_CMD_WRITE, a, d}, 16, rx);
endtask
task rd(input [4:0] a, input [7:0] exp);
    begin
        // Enable is sampled mid second byte, while the read data drives
        fork
            master.xfer({`CCPAD_CMD_READ, a, 8'h00}, 16, rx);
            begin
                repeat (150) @(posedge clk);
                chk(spi_miso_oe_n, 1'b0);
            end
        join
        chk(rx[7:0], exp);
        chk(spi_miso_oe_n, 1'b1);
    end
endtask
// Reset with given pin levels, then check the captured bits
task boot(input logic s, input logic k, input logic d);
    int n;
    begin
        master.pins(s, k, d);
        reset_n <= 1'b0;
        repeat (12) @(posedge clk);
        chk({reset_pin_n, record_activity_flag, playback_activity_flag}, 8'h03);
        reset_n <= 1'b1;
        for (n = 0; n < 100 && reset_pin_n !== 1'b1; n++)
            @(posedge clk);
        if (reset_pin_n !== 1'b1)
        begin
            num_errors++;
            results;
        end
        repeat (4) @(posedge clk);
        chk({master_clock_divider, short_frame_format, preamp_gain_x20},
            {5'h0, ~s, ~k, d});
        master.pins(1'b1, 1'b1, 1'b0);
        repeat (4) @(posedge clk);
    end
endtask
// One sample on both paths
task smp(input [15:0] a, input [15:0] p);
    begin
        @(posedge clk);
        adc_sample <= a;
        audio_serial_in <= p;
        frame_sync <= 1'b1;
        @(posedge clk);
        frame_sync <= 1'b0;
        repeat (4) @(posedge clk);
    end
endtask
// ---------------------------------------------------------------
// Main sequence
// ---------------------------------------------------------------
initial
begin
    reset_n = 1'b0;
    frame_sync = 1'b0;
    adc_sample = 16'h0000;
    audio_serial_in = 16'h0000;
    num_errors = 0;
    n_tests = 0;
    boot(1'b1, 1'b1, 1'b0);
    for (i = 0; i < 9; i++)
        wr(rows[i].a, rows[i].d);
    for (i = 0; i < 9; i++)
        rd(rows[i].a, rows[i].d);
    chk({master_clock_divider, short_frame_format,
        preamp_gain_x20, digital_loopback}, 8'h01);
    chk({record_activity_flag, playback_activity_flag, playback_power_down}, 8'h01);
    // Unknown codes and an aborted write must store nothing
    for (i = 0; i < 8; i++)
        if (i != `CCPAD_CMD_READ && i != `CCPAD_CMD_WRITE)
            master.xfer({i[2:0], `CCPAD_REG_ON_COUNT, 8'hff}, 16, rx);
    master.xfer({`CCPAD_CMD_WRITE, `CCPAD_REG_ON_COUNT, 8'hff}, 10, rx);
    rd(`CCPAD_REG_ON_COUNT, 8'h03);
    wr(`CCPAD_REG_STATUS, 8'hff);
    rd(`CCPAD_REG_STATUS, 8'h00);
    // Record count broken by a sample equal to the threshold
    for (i = 0; i < 6; i++)
    begin
        smp(i == 2 ? 16'h027f : 16'hfd80, 16'h8000);
        if (i == 2)
            chk({record_activity_flag, playback_activity_flag}, 8'h01);
        if (i == 4)
            chk(record_activity_flag, 8'h00);
    end
    chk({record_activity_flag, playback_power_down}, 8'h02);
    rd(`CCPAD_REG_STATUS, 8'h03);
    smp(16'h0000, 16'h8000);
    smp(16'h7fff, 16'h8000);
    smp(16'h0000, 16'h8000);
    chk(record_activity_flag, 8'h01);
    smp(16'h0200, 16'h8000);
    chk({record_activity_flag, playback_activity_flag}, 8'h01);
    wr(`CCPAD_REG_REC_THR, 8'h00);
    chk({record_activity_flag, playback_activity_flag}, 8'h03);
    boot(1'b0, 1'b0, 1'b1);
    results;
end
endmodule
